// *** rtl/spf_pkg.sv ***
package spf_pkg;
  // register port addresses
  localparam logic [1:0] A_CTRL = 2'h0;
  localparam logic [1:0] A_SIZE = 2'h1;
  localparam logic [1:0] A_DATA = 2'h2;
  // status_control_reg fields
  localparam int C_RATE_LSB = 0;
  localparam int C_MSB_FIRST = 3;
  localparam int C_ERR_IE = 4;
  localparam int C_FDE = 5;
  localparam int C_RX_IE = 6;
  localparam int C_MSTR = 7;
  localparam int C_CPOL = 8;
  localparam int C_CPHA = 9;
  localparam int C_EN = 10;
  localparam int C_TX_IE = 11;
  localparam int F_RXF = 12;
  localparam int F_OVF = 13;
  localparam int F_MODE_FAULT_FLAG = 14;
  localparam int F_TXE = 15;
  // size_control_reg fields
  localparam int S_OD = 4;
  localparam logic [11:0] CFG_RST = 12'h000;
  localparam logic [3:0] DS_RST = 4'hF;
  localparam logic [4:0] MIN_BITS = 5'h02;
  // partner clock: core period and serial clock period in ns
  localparam int CORE_NS = 25;
  localparam int EXT_SCLK_NS = 200;
  localparam logic [7:0] EXT_HALF_CYC = 8'(EXT_SCLK_NS / (2 * CORE_NS));
endpackage : spf_pkg

// *** rtl/spf_link_if.sv ***
`timescale 1ns/1ps
interface spf_link_if;
  logic ss_n;
  logic dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe;
  logic dev_miso_o, dev_miso_oe;
  logic ext_sclk_o, ext_sclk_oe, ext_mosi_o, ext_mosi_oe;
  logic sclk, mosi, miso;
  // released lines float high through the pull-up
  assign sclk = dev_sclk_oe ? dev_sclk_o : (ext_sclk_oe ? ext_sclk_o : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (ext_mosi_oe ? ext_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : 1'b1;
  modport dev (input ss_n, sclk, mosi, miso,
               output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe,
               output dev_miso_o, dev_miso_oe);
  modport ext (input sclk, miso,
               output ss_n, ext_sclk_o, ext_sclk_oe, ext_mosi_o, ext_mosi_oe);
endinterface : spf_link_if

// *** rtl/spf_dev_end.sv ***
// Summary of operation
// - master_select 0 slave, 1 master
// - master starts frame on tx_data_reg write
// - empty shifter loads at once, sets tx_empty_flag
// - rate_select sets master baud divisor
// - master frame end sets rx_full, copies word
// - rx read clears full; tx write clears empty while shifter full
// - slave receives only while module enabled
// - deselected slave keeps shifter contents
// - slave frame done copies word, sets full
// - slave software reads before next frame
// - master keeps sclk at most half clock
// - late slave write shifts old data out
// - slave starts on sclk edge or select fall
// - sclk idles at polarity before enabling
// - open drain drives low only
// - slave drives miso only when selected
// - master drives sclk; two half periods per bit
// - deselect mid-frame ignores further sclk edges
// - deselect in frame sets mode fault when fde set
// - master uses select for mode fault
// - select ignored when disabled or unguarded master
`timescale 1ns/1ps
module spf_dev_end
  import spf_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // event outputs
  output logic             o_rx_irq,
  output logic             o_tx_irq,
  // serial link
  spf_link_if.dev          link
);

  typedef struct packed {
    logic [11:0] cfg;
    logic [3:0]  ds;
    logic        od;
    logic        rx_full;
    logic        ovf;
    logic        mode_fault_flag;
    logic        tx_empty;
    logic [15:0] tx_buf;
    logic [15:0] sh;
    logic        sh_full;
    logic [15:0] rx_buf;
    logic [15:0] rx_acc;
    logic        act;
    logic [4:0]  bit_i;
    logic [4:0]  h;
    logic [7:0]  cnt;
    logic [2:0]  sy_ss;
    logic [2:0]  sy_sc;
    logic [1:0]  sy_mosi;
    logic [1:0]  sy_miso;
    logic [15:0] rdata;
    logic        sclk_o;
    logic        sclk_oe;
    logic        mosi_o;
    logic        mosi_oe;
    logic        miso_o;
    logic        miso_oe;
  } spf_dev_s;

  spf_dev_s s_r, s_nxt;

  logic       en, mstr, cpol, cpha, msb, fde;
  logic [4:0] nb;
  logic [7:0] half;
  logic       ss, ss_fall, lead, sc_edge, din;
  logic       drv_m, drv_s;

  assign en      = s_r.cfg[C_EN];
  assign mstr    = s_r.cfg[C_MSTR];
  assign cpol    = s_r.cfg[C_CPOL];
  assign cpha    = s_r.cfg[C_CPHA];
  assign msb     = s_r.cfg[C_MSB_FIRST];
  assign fde     = s_r.cfg[C_FDE];
  assign nb      = (s_r.ds == 4'h0) ? MIN_BITS : 5'({1'b0, s_r.ds} + 5'h01);
  // half bit time of 1 << rate cycles, divisor 2..256
  assign half    = 8'((9'h001 << s_r.cfg[C_RATE_LSB +: 3]) - 9'h001);
  assign ss      = s_r.sy_ss[1];
  assign ss_fall = s_r.sy_ss[2] & ~ss;
  assign sc_edge = s_r.sy_sc[2] ^ s_r.sy_sc[1];
  assign lead    = sc_edge & (s_r.sy_sc[2] == cpol);
  assign din     = mstr ? s_r.sy_miso[1] : s_r.sy_mosi[1];

  function automatic logic [3:0] bit_pos(input logic [4:0] i,
                                         input logic [4:0] n,
                                         input logic       m);
    bit_pos = m ? 4'(n - 5'h01 - i) : i[3:0];
  endfunction : bit_pos

  always_comb begin
    s_nxt = s_r;
    s_nxt.sy_ss   = {s_r.sy_ss[1:0], link.ss_n};
    s_nxt.sy_sc   = {s_r.sy_sc[1:0], link.sclk};
    s_nxt.sy_mosi = {s_r.sy_mosi[0], link.mosi};
    s_nxt.sy_miso = {s_r.sy_miso[0], link.miso};
    // register reads, data valid next cycle
    s_nxt.rdata = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        A_CTRL:  s_nxt.rdata = {s_r.tx_empty, s_r.mode_fault_flag, s_r.ovf, s_r.rx_full,
                                s_r.cfg};
        A_SIZE:  s_nxt.rdata = {11'h000, s_r.od, s_r.ds};
        A_DATA: begin
          s_nxt.rdata   = s_r.rx_buf;
          s_nxt.rx_full = 1'b0;
        end
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    // register writes; ovf and mode fault flags write one to clear
    if (i_wr) begin
      case (i_addr)
        A_CTRL: begin
          s_nxt.cfg = i_wdata[11:0];
          if (i_wdata[F_OVF]) s_nxt.ovf = 1'b0;
          if (i_wdata[F_MODE_FAULT_FLAG]) s_nxt.mode_fault_flag = 1'b0;
        end
        A_SIZE: begin
          s_nxt.ds = i_wdata[3:0];
          s_nxt.od = i_wdata[S_OD];
        end
        A_DATA: begin
          s_nxt.tx_buf   = i_wdata;
          s_nxt.tx_empty = 1'b0;
        end
        default: ;
      endcase
    end
    // buffer to shifter whenever the shifter is free
    if (!s_r.act && !s_r.sh_full) begin
      if (i_wr && i_addr == A_DATA) begin
        s_nxt.sh       = i_wdata;
        s_nxt.sh_full  = 1'b1;
        s_nxt.tx_empty = 1'b1;
      end else if (!s_r.tx_empty) begin
        s_nxt.sh       = s_r.tx_buf;
        s_nxt.sh_full  = 1'b1;
        s_nxt.tx_empty = 1'b1;
      end
    end
    if (!en) begin
      s_nxt.act = 1'b0;
    end else if (mstr) begin
      if (fde && !ss) begin
        s_nxt.mode_fault_flag = 1'b1;
        s_nxt.act  = 1'b0;
      end else if (!s_r.act) begin
        if (s_r.sh_full) begin
          s_nxt.act    = 1'b1;
          s_nxt.h      = 5'h00;
          s_nxt.cnt    = 8'h00;
          s_nxt.bit_i  = 5'h00;
          s_nxt.rx_acc = 16'h0000;
        end
      end else if (s_r.cnt == half) begin
        s_nxt.cnt = 8'h00;
        s_nxt.h   = 5'(s_r.h + 5'h01);
        if (s_r.h[0]) begin
          // sample late in the odd half to cover the input synchroniser
          s_nxt.rx_acc[bit_pos(s_r.bit_i, nb, msb)] = din;
          s_nxt.bit_i = 5'(s_r.bit_i + 5'h01);
        end
        if (s_r.h == 5'(nb + nb - 5'h01)) begin
          s_nxt.act     = 1'b0;
          s_nxt.sh_full = 1'b0;
          if (s_r.rx_full) begin
            s_nxt.ovf = 1'b1;
          end else begin
            s_nxt.rx_buf  = s_nxt.rx_acc;
            s_nxt.rx_full = 1'b1;
          end
        end
      end else begin
        s_nxt.cnt = 8'(s_r.cnt + 8'h01);
      end
    end else begin
      if (s_r.act && ss) begin
        s_nxt.act = 1'b0;
        if (fde) s_nxt.mode_fault_flag = 1'b1;
      end else if (!s_r.act && !ss && (cpha ? lead : ss_fall)) begin
        s_nxt.act    = 1'b1;
        s_nxt.bit_i  = 5'h00;
        s_nxt.rx_acc = 16'h0000;
      end else if (s_r.act && sc_edge) begin
        if (lead ^ cpha) begin
          s_nxt.rx_acc[bit_pos(s_r.bit_i, nb, msb)] = din;
          if (s_r.bit_i == 5'(nb - 5'h01)) begin
            s_nxt.act     = 1'b0;
            s_nxt.sh_full = 1'b0;
            if (s_r.rx_full) begin
              s_nxt.ovf = 1'b1;
            end else begin
              s_nxt.rx_buf  = s_nxt.rx_acc;
              s_nxt.rx_full = 1'b1;
            end
          end
        end else begin
          s_nxt.bit_i = 5'(s_r.bit_i + 5'h01);
        end
      end
    end
    // pin drivers; shifter word itself is never altered by sclk
    drv_m = s_nxt.cfg[C_EN] & s_nxt.cfg[C_MSTR];
    drv_s = s_nxt.cfg[C_EN] & ~s_nxt.cfg[C_MSTR] & ~ss;
    s_nxt.sclk_o = s_nxt.act ? (s_nxt.cfg[C_CPOL] ^ s_nxt.cfg[C_CPHA]
                                ^ s_nxt.h[0]) : s_nxt.cfg[C_CPOL];
    s_nxt.mosi_o = s_nxt.sh[bit_pos(s_nxt.bit_i, nb, msb)];
    s_nxt.miso_o = s_nxt.mosi_o;
    s_nxt.sclk_oe = drv_m & (~s_nxt.od | ~s_nxt.sclk_o);
    s_nxt.mosi_oe = drv_m & (~s_nxt.od | ~s_nxt.mosi_o);
    s_nxt.miso_oe = drv_s & (~s_nxt.od | ~s_nxt.miso_o);
    if (s_nxt.od) begin
      s_nxt.sclk_o = 1'b0;
      s_nxt.mosi_o = 1'b0;
      s_nxt.miso_o = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r          <= '0;
      s_r.cfg      <= CFG_RST;
      s_r.ds       <= DS_RST;
      s_r.tx_empty <= 1'b1;
      s_r.sy_ss    <= 3'h7;
      s_r.sy_sc    <= 3'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata          = s_r.rdata;
  assign o_rx_irq         = (s_r.rx_full & s_r.cfg[C_RX_IE]) |
                            (s_r.cfg[C_ERR_IE] & (s_r.ovf | s_r.mode_fault_flag));
  assign o_tx_irq         = s_r.tx_empty & s_r.cfg[C_TX_IE];
  assign link.dev_sclk_o  = s_r.sclk_o;
  assign link.dev_sclk_oe = s_r.sclk_oe;
  assign link.dev_mosi_o  = s_r.mosi_o;
  assign link.dev_mosi_oe = s_r.mosi_oe;
  assign link.dev_miso_o  = s_r.miso_o;
  assign link.dev_miso_oe = s_r.miso_oe;

endmodule : spf_dev_end

// *** rtl/spf_ext_end.sv ***
`timescale 1ns/1ps
module spf_ext_end
  import spf_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  // frame request
  input  wire logic        i_start,
  input  wire logic [15:0] i_tx_data,
  input  wire logic [4:0]  i_nbits,
  input  wire logic        i_cpol,
  input  wire logic        i_cpha,
  input  wire logic        i_msb_first,
  // frame answer
  output logic             o_busy,
  output logic             o_done,
  output logic      [15:0] o_rx_data,
  // serial link
  spf_link_if.ext          link
);

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_RUN, ST_HOLD, ST_GAP}
    spf_ext_st_e;

  typedef struct packed {
    spf_ext_st_e st;
    logic [7:0]  cnt;
    logic [4:0]  h;
    logic [4:0]  bit_i;
    logic [4:0]  nb;
    logic        cpol;
    logic        cpha;
    logic        msb;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [1:0]  sy_miso;
    logic        ss_n;
    logic        sclk;
    logic        mosi;
    logic        done;
  } spf_ext_s;

  spf_ext_s s_r, s_nxt;
  logic     half_end;

  assign half_end = (s_r.cnt == 8'(EXT_HALF_CYC - 8'h01));

  always_comb begin
    s_nxt         = s_r;
    s_nxt.sy_miso = {s_r.sy_miso[0], link.miso};
    s_nxt.done    = 1'b0;
    s_nxt.cnt     = half_end ? 8'h00 : 8'(s_r.cnt + 8'h01);
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.cnt = 8'h00;
        if (i_start) begin
          s_nxt.st    = ST_SETUP;
          s_nxt.tx    = i_tx_data;
          s_nxt.nb    = (i_nbits < MIN_BITS) ? MIN_BITS : i_nbits;
          s_nxt.cpol  = i_cpol;
          s_nxt.cpha  = i_cpha;
          s_nxt.msb   = i_msb_first;
          s_nxt.rx    = 16'h0000;
          s_nxt.bit_i = 5'h00;
          s_nxt.h     = 5'h00;
        end
      end
      ST_SETUP: if (half_end) s_nxt.st = ST_RUN;
      ST_RUN: if (half_end) begin
        s_nxt.h = 5'(s_r.h + 5'h01);
        if (s_r.h[0]) begin
          s_nxt.rx[s_r.msb ? 4'(s_r.nb - 5'h01 - s_r.bit_i)
                           : s_r.bit_i[3:0]] = s_r.sy_miso[1];
          s_nxt.bit_i = 5'(s_r.bit_i + 5'h01);
        end
        if (s_r.h == 5'(s_r.nb + s_r.nb - 5'h01)) s_nxt.st = ST_HOLD;
      end
      ST_HOLD: if (half_end) begin
        s_nxt.st   = ST_GAP;
        s_nxt.done = 1'b1;
      end
      ST_GAP: if (half_end) s_nxt.st = ST_IDLE;
      default: s_nxt.st = ST_IDLE;
    endcase
    // select low from setup through hold, sclk idles outside run
    s_nxt.ss_n = (s_nxt.st == ST_IDLE) || (s_nxt.st == ST_GAP);
    s_nxt.sclk = (s_nxt.st == ST_RUN) ? (s_nxt.cpol ^ s_nxt.cpha ^ s_nxt.h[0])
                                      : s_nxt.cpol;
    s_nxt.mosi = s_nxt.tx[s_nxt.msb ? 4'(s_nxt.nb - 5'h01 - s_nxt.bit_i)
                                    : s_nxt.bit_i[3:0]];
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r      <= '0;
      s_r.st   <= ST_IDLE;
      s_r.nb   <= MIN_BITS;
      s_r.ss_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_busy           = (s_r.st != ST_IDLE);
  assign o_done           = s_r.done;
  assign o_rx_data        = s_r.rx;
  assign link.ss_n        = s_r.ss_n;
  assign link.ext_sclk_o  = s_r.sclk;
  assign link.ext_sclk_oe = 1'b1;
  assign link.ext_mosi_o  = s_r.mosi;
  assign link.ext_mosi_oe = 1'b1;

endmodule : spf_ext_end

// *** dv/spf_link_checker.sv ***
`timescale 1ns/1ps
module spf_link_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // link signals
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic dev_sclk_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  a_miso_off_desel: assert property (ss_n [*5] |-> !dev_miso_oe)
    else $error("miso driven while deselected");
  a_miso_needs_sel: assert property (
    $rose(dev_miso_oe) |-> !ss_n && !$past(ss_n))
    else $error("miso enabled without select low");
  a_sclk_miso_excl: assert property (!(dev_sclk_oe && dev_miso_oe))
    else $error("clock and slave data driven together");
  a_mosi_miso_excl: assert property (!(dev_mosi_oe && dev_miso_oe))
    else $error("master and slave data driven together");
  a_sclk_half_min: assert property (
    $changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock half period too short");
  a_sclk_idle_sel: assert property ($fell(ss_n) |=> $stable(sclk) [*3])
    else $error("serial clock moved right after select");
  a_sel_low_frame: assert property ($fell(ss_n) |-> !ss_n [*8])
    else $error("select released too early");
  a_sel_gap: assert property ($rose(ss_n) |-> ss_n [*4])
    else $error("select gap too short");

  c_sel_frame: cover property ($fell(ss_n));
  c_miso_on: cover property ($rose(dev_miso_oe));
  c_master_clk: cover property (dev_sclk_oe && $changed(sclk));
endmodule : spf_link_checker

// *** dv/tb_spi_master_slave_core.sv ***
`timescale 1ns/1ps
module tb_spi_master_slave_core;
  import spf_pkg::*;
  logic        clk, rstn, wr, rd, start, cpha, msbf, busy, done;
  logic        rxirq, txirq;
  logic        rd_q = 1'b0;
  logic [1:0]  addr;
  logic [4:0]  nbits;
  logic [15:0] wdata, rdata, txd, rxd, cfg, msk, cap, w0, w1, t;
  logic [31:0] rq[$], eq[$];
  int          error_cnt, checked, hi_cnt, edge_cnt, n;

  spf_link_if spf_link_if_inst();
  spf_dev_end spf_dev_end_inst (.i_core_clk(clk), .i_resetn(rstn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_rx_irq(rxirq), .o_tx_irq(txirq), .link(spf_link_if_inst));
  spf_ext_end spf_ext_end_inst (.i_core_clk(clk), .i_resetn(rstn),
    .i_start(start), .i_tx_data(txd), .i_nbits(nbits), .i_cpol(1'b0),
    .i_cpha(cpha), .i_msb_first(msbf), .o_busy(busy), .o_done(done),
    .o_rx_data(rxd), .link(spf_link_if_inst));
  spf_link_checker spf_link_checker_inst (.i_core_clk(clk), .i_resetn(rstn),
    .ss_n(spf_link_if_inst.ss_n), .sclk(spf_link_if_inst.sclk),
    .dev_sclk_oe(spf_link_if_inst.dev_sclk_oe),
    .dev_mosi_oe(spf_link_if_inst.dev_mosi_oe),
    .dev_miso_oe(spf_link_if_inst.dev_miso_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task cmp_word(input string nm, input logic [31:0] e, input logic [15:0] v);
    checked++;
    if ((v & e[31:16]) !== e[15:0]) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e[15:0], v);
    end
  endtask : cmp_word

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // result watcher: oldest note against each result
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) cmp_word("rdata", rq.pop_front(), rdata);
    if (done === 1'b1) cmp_word("ext_rx", eq.pop_front(), rxd);
  end

  // master clock and data observed on the wire
  always @(posedge clk)
    if (spf_link_if_inst.dev_sclk_oe === 1'b1 && spf_link_if_inst.sclk === 1'b1)
      hi_cnt++;
  always @(posedge spf_link_if_inst.sclk)
    if (spf_link_if_inst.dev_sclk_oe === 1'b1) edge_cnt++;
  always @(negedge spf_link_if_inst.sclk)
    if (spf_link_if_inst.dev_sclk_oe === 1'b1)
      cap <= {cap[14:0], spf_link_if_inst.mosi};

  task wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk); addr <= a; rd <= 1'b1; rq.push_back({m, e});
    @(posedge clk); rd <= 1'b0;
  endtask : rd_reg

  task ext_frame(input logic [15:0] d, input logic [31:0] e);
    int w;
    w = 0;
    @(posedge clk); txd <= d; start <= 1'b1; eq.push_back(e);
    @(posedge clk); start <= 1'b0;
    do @(negedge clk); while (busy !== 1'b0 && ++w < 600);
    if (w >= 600) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask : ext_frame

  task setup(input logic m, f, ph, of, input int r, nb, input logic en);
    cfg = 16'h0000; cfg[C_MSTR] = m; cfg[C_FDE] = f; cfg[C_CPHA] = ph;
    cfg[C_MSB_FIRST] = of; cfg[2:0] = 3'(r);
    wr_reg(A_CTRL, cfg);
    wr_reg(A_SIZE, 16'(nb - 1));
    cfg[C_EN] = en;
    wr_reg(A_CTRL, cfg);
    cpha <= ph; msbf <= of; nbits <= 5'(nb); msk = 16'((32'h1 << nb) - 1);
  endtask : setup

  initial begin
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; start = 1'b0; addr = 2'h0;
    wdata = 16'h0000; txd = 16'h0000; nbits = 5'h10; cpha = 1'b0;
    msbf = 1'b0; error_cnt = 0; checked = 0; cap = 16'h0000;
    void'($urandom(64));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(A_CTRL, 16'h8000, 16'hFFFF);
    rd_reg(A_SIZE, 16'h000F, 16'h001F);
    wr_reg(2'h3, 16'hFFFF);
    rd_reg(2'h3, 16'h0000, 16'hFFFF);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 2 : (i == 1) ? 16 : 2 + ($urandom % 15);
      setup(1'b0, 1'b0, i[0], i[1], 0, n, 1'b1);
      w0 = $urandom; w1 = $urandom; t = $urandom;
      wr_reg(A_DATA, w0);
      wr_reg(A_DATA, w1);
      rd_reg(A_CTRL, 16'h0000, 16'h8000);
      ext_frame(t, {msk, w0 & msk});
      rd_reg(A_CTRL, 16'h9000, 16'hB000);
      ext_frame(~t, {msk, w1 & msk});
      rd_reg(A_CTRL, 16'h3000, 16'h3000);
      rd_reg(A_DATA, t & msk, 16'hFFFF);
      rd_reg(A_CTRL, 16'h0000, 16'h1000);
      wr_reg(A_CTRL, cfg | 16'h2000);
      rd_reg(A_CTRL, 16'h0000, 16'h2000);
      $display("test slave frame %0d done", i);
    end
    setup(1'b0, 1'b0, 1'b1, 1'b1, 0, 8, 1'b0);
    ext_frame(16'h00A5, {16'h00FF, 16'h00FF});
    rd_reg(A_CTRL, 16'h0000, 16'h3000);
    $display("test disabled slave done");
    for (int r = 2; r < 4; r++) begin
      setup(1'b1, 1'b0, 1'b1, 1'b1, r, 8, 1'b1);
      hi_cnt = 0;
      edge_cnt = 0;
      t = $urandom;
      wr_reg(A_DATA, t);
      rd_reg(A_CTRL, 16'h8000, 16'h8000);
      repeat (16 * (1 << r) + 8) @(posedge clk);
      rd_reg(A_CTRL, 16'h1000, 16'h1000);
      // receive and transmit interrupt enables on, both flags set
      wr_reg(A_CTRL, cfg | 16'h0840);
      @(negedge clk);
      cmp_word("irqs", {16'h0003, 16'h0003}, {14'h0000, txirq, rxirq});
      wr_reg(A_CTRL, cfg);
      rd_reg(A_DATA, 16'h00FF, 16'hFFFF);
      cmp_word("sclk_high", {16'hFFFF, 16'(8 << r)}, 16'(hi_cnt));
      cmp_word("sclk_edges", {16'hFFFF, 16'h0008}, 16'(edge_cnt));
      cmp_word("mosi_word", {16'h00FF, t & 16'h00FF}, cap);
      $display("test master rate %0d done", r);
    end
    for (int f = 1; f >= 0; f--) begin
      setup(1'b1, f[0], 1'b1, 1'b1, 2, 8, 1'b1);
      ext_frame(16'h0000, 32'h0000_0000);
      rd_reg(A_CTRL, {1'b0, f[0], 14'h0000}, 16'h4000);
      wr_reg(A_CTRL, cfg | 16'h4000);
      $display("test mode fault detect %0d done", f);
    end
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule : tb_spi_master_slave_core
